/* verilog/kpi_pkg.sv */
// constants and types for the key pin interrupt block
package kpi_pkg;

  // pins, widths
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PIN_ENABLE  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_POLARITY    = 12'h008;

  // status and control field positions
  localparam int unsigned FLAG_BIT = 3;
  localparam int unsigned ACK_BIT  = 2;
  localparam int unsigned IE_BIT   = 1;
  localparam int unsigned MODE_BIT = 0;

  // values after reset
  localparam logic [REG_W-1:0]    RST_PIN_ENABLE = 8'h00;
  localparam logic [REG_W-1:0]    RST_POLARITY   = 8'h00;
  localparam logic [NUM_PINS-1:0] RST_SYNC       = 4'h0;
  localparam logic [DATA_W-1:0]   RST_PRDATA     = 32'h0000_0000;

  typedef enum logic {
    KPI_EDGE_ONLY,
    KPI_EDGE_LEVEL
  } kpi_detect_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } kpi_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } kpi_apb_rsp_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] prev;
    logic                flag;
    logic                ie;
    kpi_detect_t         mode;
    logic [REG_W-1:0]    pin_en;
    logic [REG_W-1:0]    pol;
    kpi_apb_rsp_t        rsp;
    logic                irq;
    logic                wake;
  } kpi_state_t;

  localparam kpi_state_t KPI_STATE_RST = '{
    sync1:  RST_SYNC,
    sync2:  RST_SYNC,
    prev:   RST_SYNC,
    flag:   1'b0,
    ie:     1'b0,
    mode:   KPI_EDGE_ONLY,
    pin_en: RST_PIN_ENABLE,
    pol:    RST_POLARITY,
    rsp:    '{prdata: RST_PRDATA, pready: 1'b0, pslverr: 1'b0},
    irq:    1'b0,
    wake:   1'b0
  };

endpackage

/* verilog/kpi_top.sv */
// key pin interrupt block with apb register access
`timescale 1ns/1ps

module kpi_top
  import kpi_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // register bus
  input  wire kpi_apb_req_t        apb_req,
  output kpi_apb_rsp_t             apb_rsp,
  // key pins, asynchronous
  input  wire logic [NUM_PINS-1:0] key_input_pin,
  // power mode status, on pclk
  input  wire logic                wait_mode,
  input  wire logic                light_stop,
  input  wire logic                deep_stop,
  // requests to the cpu and power control
  output logic                     key_irq,
  output logic                     wake_req
);

  kpi_state_t          st;
  kpi_state_t          nxt;
  logic [NUM_PINS-1:0] now_act;
  logic [NUM_PINS-1:0] edge_hit;
  logic                level_hit;
  logic                event_hit;
  logic                setup_ph;
  logic                done_ph;
  logic                wr_ctrl;
  logic                wr_en;
  logic                wr_pol;
  logic                ack_wr;
  logic                ack_ok;
  logic                addr_hit;
  logic [REG_W-1:0]    rd_byte;

  // pin evaluation; pins above NUM_PINS have no pad, so their
  // enable and polarity bits are storage only
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    // asserted when enabled and its synced level equals its polarity bit
    assign now_act[i]  = st.pin_en[i] & (st.sync2[i] == st.pol[i]);
    // deasserted last cycle, asserted now
    assign edge_hit[i] = now_act[i] & (st.prev[i] != st.pol[i]);
  end

  // run, wait and light stop all share this path
  assign level_hit = (st.mode == KPI_EDGE_LEVEL) & (|now_act);
  assign event_hit = (|edge_hit) | level_hit;

  // bus phases; pready is high only in the access cycle
  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign done_ph  = apb_req.psel & apb_req.penable & st.rsp.pready;

  assign wr_ctrl = done_ph & apb_req.pwrite & (apb_req.paddr == OFS_STATUS_CTRL);
  assign wr_en   = done_ph & apb_req.pwrite & (apb_req.paddr == OFS_PIN_ENABLE);
  assign wr_pol  = done_ph & apb_req.pwrite & (apb_req.paddr == OFS_POLARITY);

  assign ack_wr = wr_ctrl & apb_req.pwdata[ACK_BIT];
  // in edge-level mode an asserted pin blocks the clear
  assign ack_ok = ack_wr & ((st.mode == KPI_EDGE_ONLY) | ~(|now_act));

  assign addr_hit = (apb_req.paddr == OFS_STATUS_CTRL) |
                    (apb_req.paddr == OFS_PIN_ENABLE) |
                    (apb_req.paddr == OFS_POLARITY);

  // read mux
  always_comb begin
    rd_byte = '0;
    case (apb_req.paddr)
      OFS_STATUS_CTRL: begin
        // upper nibble and ack always read zero
        rd_byte[FLAG_BIT] = st.flag;
        rd_byte[IE_BIT]   = st.ie;
        rd_byte[MODE_BIT] = (st.mode == KPI_EDGE_LEVEL);
      end
      OFS_PIN_ENABLE: begin
        rd_byte = st.pin_en;
      end
      OFS_POLARITY: begin
        rd_byte = st.pol;
      end
      default: begin
        rd_byte = '0;
      end
    endcase
  end

  always_comb begin
    nxt = st;
    // two-stage synchroniser, then one more stage for edge history
    nxt.sync1 = key_input_pin;
    nxt.sync2 = st.sync1;
    nxt.prev  = st.sync2;

    // answer one cycle after setup, zero wait states
    nxt.rsp.pready  = 1'b0;
    nxt.rsp.pslverr = 1'b0;
    if (setup_ph) begin
      nxt.rsp.pready  = 1'b1;
      nxt.rsp.pslverr = ~addr_hit;
      nxt.rsp.prdata  = {{(DATA_W - REG_W){1'b0}}, rd_byte};
    end

    // flag bit in the write data is ignored
    if (wr_ctrl) begin
      nxt.ie   = apb_req.pwdata[IE_BIT];
      nxt.mode = apb_req.pwdata[MODE_BIT] ? KPI_EDGE_LEVEL : KPI_EDGE_ONLY;
    end
    if (wr_en) begin
      nxt.pin_en = apb_req.pwdata[REG_W-1:0];
    end
    if (wr_pol) begin
      nxt.pol = apb_req.pwdata[REG_W-1:0];
    end

    // a new event in the ack cycle keeps the flag set
    nxt.flag = event_hit | (st.flag & ~ack_ok);

    nxt.irq  = nxt.flag & nxt.ie;
    // clock must keep running in light stop; no async path here
    nxt.wake = nxt.irq & (wait_mode | light_stop);

    // deeper stop wipes everything, the bus side included
    if (deep_stop) begin
      nxt = KPI_STATE_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= KPI_STATE_RST;
    end else begin
      st <= nxt;
    end
  end

  assign apb_rsp  = st.rsp;
  assign key_irq  = st.irq;
  assign wake_req = st.wake;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_ctrl_done;
  assign rd_ctrl_done = done_ph & ~apb_req.pwrite &
                        (apb_req.paddr == OFS_STATUS_CTRL);

  AST_RSVD_ZERO: assert property (
    rd_ctrl_done |-> (apb_rsp.prdata[7:4] == 4'h0)
  ) else $error("status upper nibble not zero");

  AST_ACK_READS_ZERO: assert property (
    rd_ctrl_done |-> !apb_rsp.prdata[ACK_BIT]
  ) else $error("ack bit read as one");

  AST_FLAG_READ: assert property (
    rd_ctrl_done |-> (apb_rsp.prdata[FLAG_BIT] == $past(st.flag))
  ) else $error("flag read back differs from flag");

  AST_FLAG_WRITE_IGNORED: assert property (
    (wr_ctrl && apb_req.pwdata[FLAG_BIT] && !apb_req.pwdata[ACK_BIT]
     && !event_hit && !st.flag && !deep_stop) |=> !st.flag
  ) else $error("write to flag bit set the flag");

  AST_ACK_CLEARS: assert property (
    (ack_wr && !event_hit && (st.mode == KPI_EDGE_ONLY || !(|now_act)))
    |=> !st.flag
  ) else $error("ack did not clear flag");

  AST_ACK_BLOCKED: assert property (
    (ack_wr && st.flag && st.mode == KPI_EDGE_LEVEL && (|now_act)
     && !deep_stop) |=> st.flag
  ) else $error("ack cleared flag while a pin was asserted");

  AST_IRQ_MASKED: assert property (
    (!st.ie && !wr_ctrl) |=> !key_irq
  ) else $error("request with interrupt enable low");

  AST_IRQ_FOLLOWS: assert property (
    (st.ie && st.flag && !ack_wr && !wr_ctrl && !deep_stop) |=> key_irq
  ) else $error("request missing with flag and enable set");

  AST_EDGE_SETS: assert property (
    ((|edge_hit) && !deep_stop) |=> st.flag
  ) else $error("edge did not set flag");

  AST_FLAG_CAUSE: assert property (
    $rose(st.flag) |-> $past(event_hit)
  ) else $error("flag rose without an enabled pin event");

  AST_PIN_TO_EDGE: assert property (
    (|edge_hit) |-> ($past(key_input_pin, 2) != $past(key_input_pin, 3))
  ) else $error("edge seen without synchroniser latency");

  AST_LEVEL_HOLDS: assert property (
    (level_hit && !deep_stop) |=> st.flag ##1 (st.flag || !level_hit)
  ) else $error("asserted level did not hold flag");

  AST_DEEP_STOP: assert property (
    deep_stop |=> (!st.flag && !st.ie && st.pin_en == RST_PIN_ENABLE
                   && st.pol == RST_POLARITY && !key_irq)
  ) else $error("deep stop left state set");

  AST_WAKE: assert property (
    wake_req |-> (key_irq && $past(wait_mode || light_stop))
  ) else $error("wake without request or low-power mode");

  AST_PREADY_PULSE: assert property (
    apb_rsp.pready |=> !apb_rsp.pready
  ) else $error("pready held for two cycles");

  // bus answer timing; the master never counts on it, but software drivers may
  AST_PREADY_AFTER_SETUP: assert property (
    (setup_ph && !deep_stop) |=> apb_rsp.pready
  ) else $error("no pready after setup");

  AST_PREADY_CAUSE: assert property (
    apb_rsp.pready |-> $past(setup_ph)
  ) else $error("pready without a setup cycle");

  AST_PSLVERR_UNMAPPED: assert property (
    (setup_ph && !addr_hit && !deep_stop) |=> apb_rsp.pslverr
  ) else $error("unmapped address answered without error");

  AST_PSLVERR_MAPPED: assert property (
    (setup_ph && addr_hit) |=> !apb_rsp.pslverr
  ) else $error("mapped address answered with error");

  AST_PRDATA_UPPER: assert property (
    apb_rsp.pready |-> (apb_rsp.prdata[DATA_W-1:REG_W] == '0)
  ) else $error("read data above the register byte not zero");

  AST_PIN_EN_WRITE: assert property (
    (wr_en && !deep_stop)
    |=> (st.pin_en == $past(apb_req.pwdata[REG_W-1:0]))
  ) else $error("pin enable write lost");

  AST_POL_WRITE: assert property (
    (wr_pol && !deep_stop)
    |=> (st.pol == $past(apb_req.pwdata[REG_W-1:0]))
  ) else $error("polarity write lost");

  AST_PIN_EN_READ: assert property (
    (done_ph && !apb_req.pwrite && apb_req.paddr == OFS_PIN_ENABLE)
    |-> (apb_rsp.prdata[REG_W-1:0] == $past(st.pin_en))
  ) else $error("pin enable read back differs");

  AST_POL_READ: assert property (
    (done_ph && !apb_req.pwrite && apb_req.paddr == OFS_POLARITY)
    |-> (apb_rsp.prdata[REG_W-1:0] == $past(st.pol))
  ) else $error("polarity read back differs");

  AST_DISABLED_IGNORED: assert property (
    (st.pin_en[NUM_PINS-1:0] == '0) |-> !event_hit
  ) else $error("event from a disabled pin");

  AST_EDGE_ONLY_NO_LEVEL: assert property (
    (st.mode == KPI_EDGE_ONLY) |-> (event_hit == (|edge_hit))
  ) else $error("level event in edge only style");

  AST_EDGE_NEEDS_CHANGE: assert property (
    (|edge_hit) |-> (st.prev != st.sync2)
  ) else $error("edge seen on a steady pin");

  AST_ANY_PIN_IRQ: assert property (
    (event_hit && st.ie && !wr_ctrl && !deep_stop) |=> key_irq
  ) else $error("enabled event gave no request");

  AST_WAKE_LOW_POWER: assert property (
    ((wait_mode || light_stop) && st.ie && st.flag && !wr_ctrl && !deep_stop)
    |=> wake_req
  ) else $error("pending request did not wake");

  AST_NO_WAKE_IN_RUN: assert property (
    (!wait_mode && !light_stop) |=> !wake_req
  ) else $error("wake outside low-power modes");

  AST_FLAG_STICKY: assert property (
    (st.flag && !ack_wr && !deep_stop) |=> st.flag
  ) else $error("flag cleared without acknowledge");

  AST_CTRL_WRITE: assert property (
    (wr_ctrl && !deep_stop) |=> ((st.ie == $past(apb_req.pwdata[IE_BIT]))
      && ((st.mode == KPI_EDGE_LEVEL) == $past(apb_req.pwdata[MODE_BIT])))
  ) else $error("control write lost");

  AST_DEEP_BUS: assert property (
    deep_stop |=> (!apb_rsp.pready && !apb_rsp.pslverr && !wake_req
                   && st.sync1 == RST_SYNC)
  ) else $error("deep stop left bus or wake state set");

  // a broken synchroniser would let metastable values reach the edge logic
  AST_SYNC_STAGE: assert property (
    !deep_stop |=> (st.sync2 == $past(st.sync1))
  ) else $error("synchroniser stage skipped");

  COV_UNMAPPED: cover property (
    setup_ph && !addr_hit ##1 apb_rsp.pslverr
  );

  COV_EDGE_IRQ: cover property (
    (|edge_hit) && st.ie ##1 key_irq
  );

  COV_ACK_BLOCKED: cover property (
    ack_wr && st.mode == KPI_EDGE_LEVEL && (|now_act)
  );

  COV_WAKE: cover property (
    light_stop ##[1:20] wake_req
  );

  COV_ACK_CLEAR: cover property (
    st.flag && ack_wr ##1 !st.flag
  );

endmodule

/* tb/kpi_key_model.sv */
// behavioural key switches driving the asynchronous key pins
`timescale 1ns/1ps

module kpi_key_model
  import kpi_pkg::*;
(
  // clock
  input  wire logic                pclk,
  // press command and wanted polarity from the bench
  input  wire logic [NUM_PINS-1:0] press,
  input  wire logic [NUM_PINS-1:0] pol,
  // key pins
  output logic [NUM_PINS-1:0]      key_input_pin
);
  // pressed key shows its asserted level, a released key its idle level
  always_ff @(posedge pclk) begin
    key_input_pin <= ~(press ^ pol);
  end
endmodule

/* tb/kpi_top_tb.sv */
// self-checking bench for the key pin interrupt block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end

module kpi_top_tb;
  import kpi_pkg::*;
  logic                pclk, presetn, wait_mode, light_stop, deep_stop;
  logic                key_irq, wake_req, err;
  kpi_apb_req_t        req;
  kpi_apb_rsp_t        rsp;
  logic [NUM_PINS-1:0] press, pol, pins;
  logic [DATA_W-1:0]   rd;
  int                  error_cnt, n_checks;

  kpi_key_model key_u (.pclk(pclk), .press(press), .pol(pol), .key_input_pin(pins));
  kpi_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .key_input_pin(pins), .wait_mode(wait_mode), .light_stop(light_stop),
    .deep_stop(deep_stop), .key_irq(key_irq), .wake_req(wake_req));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // one apb transfer; waits for pready, never assumes its latency
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  // pins need several stable cycles to pass the synchronizer
  task automatic keys(input logic [NUM_PINS-1:0] p);
    @(posedge pclk);
    press <= p;
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_reset();
    rchk(OFS_STATUS_CTRL, 32'h0000_0000);
    rchk(OFS_PIN_ENABLE, 32'h0000_0000);
    rchk(OFS_POLARITY, 32'h0000_0000);
    apb(1'b1, OFS_PIN_ENABLE, 32'h0000_00F0);
    rchk(OFS_PIN_ENABLE, 32'h0000_00F0);
    apb(1'b1, OFS_PIN_ENABLE, 32'h0000_0000);
    rchk(12'h00C, 32'h0000_0000);
    `CHK(err, 1'b1)
    $display("test reset done");
  endtask

  task automatic t_edge();
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_POLARITY, 32'h0000_0000);
    apb(1'b1, OFS_PIN_ENABLE, 32'h0000_0001);
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0004);
    keys(4'h2);
    rchk(OFS_STATUS_CTRL, 32'h0000_0000);
    keys(4'h3);
    rchk(OFS_STATUS_CTRL, 32'h0000_0008);
    `CHK(key_irq, 1'b0)
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_00FA);
    rchk(OFS_STATUS_CTRL, 32'h0000_000A);
    `CHK(key_irq, 1'b1)
    wait_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(wake_req, 1'b1)
    wait_mode <= 1'b0;
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0006);
    rchk(OFS_STATUS_CTRL, 32'h0000_0002);
    `CHK(key_irq, 1'b0)
    keys(4'h0);
    $display("test edge done");
  endtask

  task automatic t_level();
    pol <= 4'h4;
    apb(1'b1, OFS_POLARITY, 32'h0000_0004);
    apb(1'b1, OFS_PIN_ENABLE, 32'h0000_0004);
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0005);
    rchk(OFS_POLARITY, 32'h0000_0004);
    keys(4'h4);
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0005);
    rchk(OFS_STATUS_CTRL, 32'h0000_0009);
    light_stop <= 1'b1;
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    `CHK(wake_req, 1'b1)
    light_stop <= 1'b0;
    keys(4'h0);
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0005);
    rchk(OFS_STATUS_CTRL, 32'h0000_0001);
    $display("test level done");
  endtask

  task automatic t_deep();
    keys(4'h4);
    apb(1'b1, OFS_STATUS_CTRL, 32'h0000_0003);
    @(posedge pclk);
    `CHK(key_irq, 1'b1)
    deep_stop <= 1'b1;
    repeat (2) @(posedge pclk);
    deep_stop <= 1'b0;
    `CHK(key_irq, 1'b0)
    rchk(OFS_PIN_ENABLE, 32'h0000_0000);
    rchk(OFS_POLARITY, 32'h0000_0000);
    rchk(OFS_STATUS_CTRL, 32'h0000_0000);
    $display("test deep stop done");
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    req = '0;
    press = '0;
    pol = '0;
    wait_mode = 1'b0;
    light_stop = 1'b0;
    deep_stop = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_edge();
    t_level();
    t_deep();
    end_sim();
  end

  // generous bound of 10000 cycles over the roughly 150 cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule
